// >>> verilog/petc_codec.sv
`timescale 1ns/100ps
`default_nettype none
`include "petc_params.svh"
module petc_codec #(
	parameter int CELL_CLKS = `PETC_CELL_CLKS,
	parameter int ID_CELLS = `PETC_ID_CELLS,
	parameter int GAP_CELLS = `PETC_GAP_CELLS,
	parameter int STB_CLKS = `PETC_STB_CLKS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wr_cmd_n,
	input wire logic id_cmd_n,
	input wire logic rd_cmd_n,
	input wire logic rev_n,
	input wire logic wr_req_n,
	input wire logic wr_last_n,
	input wire logic [7:0] wr_byte_n,
	output logic wr_ack_n,
	output logic busy_n,
	output logic [7:0] rd_data_n,
	output logic rd_stb_n,
	output logic rd_perr_n,
	input wire logic [8:0] rd_pos,
	input wire logic [8:0] rd_neg,
	output logic [8:0] wr_flux,
	output logic wr_en,
	output logic erase_on
);
	localparam int HALF = CELL_CLKS / 2;
	localparam int CW = $clog2(CELL_CLKS + 1);
	localparam int SW = 32;

	function automatic petc_pkg::petc_char_t pack(input logic [7:0] d);
		pack = {d[7:`PETC_PAR_TRK], ~^d, d[`PETC_PAR_TRK-1:0]};
	endfunction

	function automatic logic [7:0] unpack(input petc_pkg::petc_char_t c);
		unpack = {c[8:`PETC_PAR_TRK+1], c[`PETC_PAR_TRK-1:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers; every controller line is low true

	logic [SW-1:0] sync1_q;
	logic [SW-1:0] sync2_q;
	logic [8:0] pos_prev_q;
	logic [8:0] neg_prev_q;
	logic wr_cmd;
	logic id_cmd;
	logic rd_cmd;
	logic rev;
	logic wr_req;
	logic wr_last;
	logic [7:0] wr_byte;
	logic [8:0] pos_s;
	logic [8:0] neg_s;
	logic [8:0] pos_p;
	logic [8:0] neg_p;

	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q <= {{14{1'b1}}, 18'h0};
			sync2_q <= {{14{1'b1}}, 18'h0};
			pos_prev_q <= '0;
			neg_prev_q <= '0;
		end else if (ce) begin
			sync1_q <= {wr_cmd_n, id_cmd_n, rd_cmd_n, rev_n, wr_req_n, wr_last_n, wr_byte_n,
				rd_pos, rd_neg};
			sync2_q <= sync1_q;
			pos_prev_q <= pos_s;
			neg_prev_q <= neg_s;
		end
	end

	assign wr_cmd = ~sync2_q[31];
	assign id_cmd = ~sync2_q[30];
	assign rd_cmd = ~sync2_q[29];
	assign rev = ~sync2_q[28];
	assign wr_req = ~sync2_q[27];
	assign wr_last = ~sync2_q[26];
	assign wr_byte = ~sync2_q[25:18];
	assign pos_s = sync2_q[17:9];
	assign neg_s = sync2_q[8:0];
	assign pos_p = pos_s & ~pos_prev_q;
	assign neg_p = neg_s & ~neg_prev_q;

	////////////////////////////////////////////////////////////////////////////
	// write handshake into the two-entry buffer

	logic wr_ack_q;
	logic wr_ack_n_q;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_pop;
	logic push;
	logic [8:0] buf_out;

	assign push = wr_req & ~wr_ack_q & buf_in_ready;

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ack_q <= 1'b0;
			wr_ack_n_q <= 1'b1;
		end else if (ce) begin
			if (push) begin
				wr_ack_q <= 1'b1;
				wr_ack_n_q <= 1'b0;
			end else if (!wr_req) begin
				wr_ack_q <= 1'b0;
				wr_ack_n_q <= 1'b1;
			end
		end
	end

	petc_buf2 #(
		.W(9),
		.DEPTH(`PETC_BUF_DEPTH)
	) u_buf (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.in_valid(wr_req & ~wr_ack_q),
		.in_ready(buf_in_ready),
		.in_data({wr_last, wr_byte}),
		.out_valid(buf_out_valid),
		.out_ready(buf_pop),
		.out_data(buf_out)
	);

	////////////////////////////////////////////////////////////////////////////
	// shared cell clock for all tracks

	logic [CW-1:0] cell_q;
	logic bnd;
	logic mid;

	always_ff @(posedge clk) begin
		if (rst) begin
			cell_q <= '0;
		end else if (ce) begin
			cell_q <= (cell_q == CW'(CELL_CLKS - 1)) ? '0 : cell_q + 1'b1;
		end
	end

	assign bnd = cell_q == '0;
	assign mid = cell_q == CW'(HALF);

	////////////////////////////////////////////////////////////////////////////
	// write sequencer: next character chosen at each cell boundary

	petc_pkg::petc_wstate_t st_q;
	petc_pkg::petc_wstate_t st_d;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	petc_pkg::petc_char_t chr_d;
	petc_pkg::petc_char_t msk_d;
	petc_pkg::petc_char_t cur_q;
	petc_pkg::petc_char_t mask_q;
	logic pop;

	assign buf_pop = ce & bnd & pop;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q + 1'b1;
		chr_d = `PETC_ZEROS;
		msk_d = `PETC_ZEROS;
		pop = 1'b0;
		case (st_q)
			petc_pkg::S_IDLE: begin
				cnt_d = '0;
				if (wr_cmd) begin
					st_d = id_cmd ? petc_pkg::S_ID : petc_pkg::S_PRE;
				end
			end
			petc_pkg::S_ID: begin
				msk_d[`PETC_PAR_TRK] = 1'b1;
				chr_d[`PETC_PAR_TRK] = ~cnt_q[0];
				if (cnt_q == 16'(ID_CELLS - 1)) begin
					st_d = petc_pkg::S_GAP;
					cnt_d = '0;
				end
			end
			petc_pkg::S_GAP: begin
				if (cnt_q == 16'(GAP_CELLS - 1)) begin
					st_d = petc_pkg::S_PRE;
					cnt_d = '0;
				end
			end
			petc_pkg::S_PRE: begin
				msk_d = `PETC_ONES;
				chr_d = (cnt_q == 16'(`PETC_PRE_ZEROS)) ? `PETC_ONES : `PETC_ZEROS;
				if (cnt_q == 16'(`PETC_BLK_CHARS - 1)) begin
					st_d = petc_pkg::S_DATA;
					cnt_d = '0;
				end
			end
			petc_pkg::S_DATA: begin
				msk_d = `PETC_ONES;
				if (buf_out_valid) begin
					chr_d = pack(buf_out[7:0]);
					pop = 1'b1;
					cnt_d = '0;
					if (buf_out[8]) begin
						st_d = petc_pkg::S_POST;
					end
				end else begin
					// underrun closes the block: this cell is the postamble ones
					chr_d = `PETC_ONES;
					cnt_d = 16'h0001;
					st_d = petc_pkg::S_POST;
				end
			end
			petc_pkg::S_POST: begin
				msk_d = `PETC_ONES;
				chr_d = (cnt_q == '0) ? `PETC_ONES : `PETC_ZEROS;
				if (cnt_q == 16'(`PETC_BLK_CHARS - 1)) begin
					st_d = petc_pkg::S_IDLE;
				end
			end
			default: begin
				st_d = petc_pkg::S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= petc_pkg::S_IDLE;
			cnt_q <= '0;
			cur_q <= `PETC_ZEROS;
			mask_q <= `PETC_ZEROS;
		end else if (ce && bnd) begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			cur_q <= chr_d;
			mask_q <= msk_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write flux; unmasked tracks stay at erase polarity

	logic [8:0] flux_q;
	logic wr_en_q;
	logic erase_q;
	logic wr_active;
	logic rd_active;

	assign wr_active = (st_q != petc_pkg::S_IDLE) | wr_cmd;
	assign rd_active = rd_cmd & ~wr_active;

	always_ff @(posedge clk) begin
		if (rst) begin
			flux_q <= '1;
		end else if (ce && bnd) begin
			flux_q <= ~(msk_d & chr_d);
		end else if (ce && mid) begin
			flux_q <= ~mask_q | cur_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_en_q <= 1'b0;
			erase_q <= 1'b0;
		end else if (ce) begin
			wr_en_q <= st_q != petc_pkg::S_IDLE;
			erase_q <= wr_active;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read: per-track recovery and character assembly

	logic [8:0] trk_bit;
	logic [8:0] trk_vld;
	logic [8:0] trk_lock;
	logic all_vld;

	assign all_vld = &trk_vld;

	for (genvar t = 0; t < `PETC_TRACKS; t++) begin : g_trk
		petc_trk_dec #(
			.CELL_CLKS(CELL_CLKS)
		) u_dec (
			.clk(clk),
			.rst(rst),
			.ce(ce),
			.en(rd_active),
			.rev(rev),
			.pos(pos_p[t]),
			.neg(neg_p[t]),
			.take(all_vld),
			.bit_q(trk_bit[t]),
			.vld_q(trk_vld[t]),
			.lock_q(trk_lock[t])
		);
	end

	logic first_q;
	logic post_q;
	logic pend_vld_q;
	petc_pkg::petc_char_t pend_q;
	logic post_hit;
	logic emit;

	// a ones character followed by all zeros can only be the trailing marker
	assign post_hit = pend_vld_q && (pend_q == `PETC_ONES) && (trk_bit == `PETC_ZEROS);
	assign emit = all_vld & ~post_q & ~first_q & pend_vld_q & ~post_hit;

	always_ff @(posedge clk) begin
		if (rst || !rd_active) begin
			first_q <= 1'b1;
			post_q <= 1'b0;
			pend_vld_q <= 1'b0;
			pend_q <= `PETC_ZEROS;
		end else if (ce) begin
			if (post_q && (trk_lock == '0)) begin
				first_q <= 1'b1;
				post_q <= 1'b0;
			end else if (all_vld && !post_q) begin
				if (first_q) begin
					first_q <= 1'b0;
				end else if (post_hit) begin
					post_q <= 1'b1;
					pend_vld_q <= 1'b0;
				end else begin
					pend_q <= trk_bit;
					pend_vld_q <= 1'b1;
				end
			end
		end
	end

	logic [7:0] rd_data_n_q;
	logic rd_perr_n_q;
	logic rd_stb_n_q;
	logic [7:0] stb_cnt_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_data_n_q <= 8'hFF;
			rd_perr_n_q <= 1'b1;
			rd_stb_n_q <= 1'b1;
			stb_cnt_q <= '0;
		end else if (ce) begin
			if (emit) begin
				rd_data_n_q <= ~unpack(pend_q);
				rd_perr_n_q <= ^pend_q;
				rd_stb_n_q <= 1'b0;
				stb_cnt_q <= 8'(STB_CLKS - 1);
			end else if (stb_cnt_q != '0) begin
				stb_cnt_q <= stb_cnt_q - 1'b1;
			end else begin
				rd_stb_n_q <= 1'b1;
			end
		end
	end

	logic busy_n_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			busy_n_q <= 1'b1;
		end else if (ce) begin
			busy_n_q <= ~((st_q != petc_pkg::S_IDLE) | (|trk_lock));
		end
	end

	assign wr_ack_n = wr_ack_n_q;
	assign busy_n = busy_n_q;
	assign rd_data_n = rd_data_n_q;
	assign rd_stb_n = rd_stb_n_q;
	assign rd_perr_n = rd_perr_n_q;
	assign wr_flux = flux_q;
	assign wr_en = wr_en_q;
	assign erase_on = erase_q;

	////////////////////////////////////////////////////////////////////////////
	// checks

	a_mid_value: assert property (@(posedge clk) disable iff (rst)
		(ce && mid) |=> ((flux_q & $past(mask_q)) == ($past(cur_q) & $past(mask_q))))
		else $error("mid-cell flux does not match data bit");

	a_phase_bit: assert property (@(posedge clk) disable iff (rst)
		(ce && bnd && (st_q != petc_pkg::S_IDLE) && (st_q != petc_pkg::S_GAP))
		|=> ((($past(flux_q) ^ flux_q) & $past(mask_q & msk_d))
		== $past(~(cur_q ^ chr_d) & mask_q & msk_d)))
		else $error("boundary transition wrong for repeated bit");

	a_cell_wrap: assert property (@(posedge clk) disable iff (rst)
		(ce && (cell_q == CW'(CELL_CLKS - 1))) |=> bnd)
		else $error("cell counter did not wrap at cell length");

	a_id_track: assert property (@(posedge clk) disable iff (rst)
		(ce && bnd && (st_q == petc_pkg::S_ID)) |=> (mask_q == (9'h001 << `PETC_PAR_TRK)))
		else $error("id burst drives a track other than parity track");

	a_gap_len: assert property (@(posedge clk) disable iff (rst)
		(ce && bnd && (st_q == petc_pkg::S_GAP) && (st_d == petc_pkg::S_PRE))
		|-> (cnt_q == 16'(GAP_CELLS - 1)))
		else $error("gap after id burst too short");

	a_odd_parity: assert property (@(posedge clk) disable iff (rst)
		(ce && bnd && (st_q == petc_pkg::S_DATA) && pop) |=> (^cur_q == 1'b1))
		else $error("written character has even parity");

	a_pre_ones: assert property (@(posedge clk) disable iff (rst)
		(ce && bnd && (st_q == petc_pkg::S_PRE) && (st_d == petc_pkg::S_DATA))
		|=> ((cur_q == `PETC_ONES) && ($past(cnt_q) == 16'(`PETC_PRE_ZEROS))))
		else $error("preamble does not end with ones character");

	a_post_zero: assert property (@(posedge clk) disable iff (rst)
		(ce && bnd && (st_q == petc_pkg::S_POST) && (st_d == petc_pkg::S_IDLE))
		|=> (cur_q == `PETC_ZEROS))
		else $error("postamble does not end with zeros");

	a_erase_write: assert property (@(posedge clk) disable iff (rst)
		(ce && (st_q != petc_pkg::S_IDLE)) |-> (!rd_active ##1 erase_q))
		else $error("erase head off during write");

	a_perr_flag: assert property (@(posedge clk) disable iff (rst)
		(ce && emit) |=> ((rd_perr_n_q == ^$past(pend_q)) && !rd_stb_n_q))
		else $error("parity error flag wrong on read character");
endmodule
`default_nettype wire

// >>> verilog/petc_params.svh
`ifndef PETC_PARAMS_SVH
`define PETC_PARAMS_SVH

// tape motion and recording density
`define PETC_TAPE_IPS 25
`define PETC_BPI 1600
`define PETC_CLK_NS 40
// cell time in ns and in clocks
`define PETC_CELL_NS (1000000000 / (`PETC_BPI * `PETC_TAPE_IPS))
`define PETC_CELL_CLKS (`PETC_CELL_NS / `PETC_CLK_NS)
// framing
`define PETC_TRACKS 9
`define PETC_PAR_TRK 3
`define PETC_PRE_ZEROS 40
`define PETC_BLK_CHARS 41
`define PETC_ONES 9'h1FF
`define PETC_ZEROS 9'h000
// gap after the identification burst, in thousandths of an inch
`define PETC_GAP_MILLI_IN 500
`define PETC_GAP_CELLS ((`PETC_GAP_MILLI_IN * `PETC_BPI + 999) / 1000)
`define PETC_ID_CELLS 1600
// read strobe width towards the controller
`define PETC_STB_CLKS 8
`define PETC_BUF_DEPTH 2

`endif

// >>> verilog/petc_pkg.sv
package petc_pkg;
	typedef enum {
		S_IDLE,
		S_ID,
		S_GAP,
		S_PRE,
		S_DATA,
		S_POST
	} petc_wstate_t;

	typedef logic [8:0] petc_char_t;
endpackage

// >>> verilog/petc_buf2.sv
`timescale 1ns/100ps
`default_nettype none
module petc_buf2 #(
	parameter int W = 9,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = cnt_q < (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data = mem[rp_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem[wp_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else if (ce) begin
			if (push) begin
				wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> verilog/petc_trk_dec.sv
`timescale 1ns/100ps
`default_nettype none
module petc_trk_dec #(
	parameter int CELL_CLKS = 625
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic en,
	input wire logic rev,
	input wire logic pos,
	input wire logic neg,
	input wire logic take,
	output logic bit_q,
	output logic vld_q,
	output logic lock_q
);
	localparam int HALF = CELL_CLKS / 2;
	localparam int QTR = CELL_CLKS / 4;
	localparam int CW = $clog2(2 * CELL_CLKS);

	logic [CW-1:0] cnt_q;
	logic pred_q;
	logic bnd_q;
	logic miss_q;
	logic p;
	logic n;
	logic in_bnd;
	logic late;
	logic lost;

	// reverse motion flips pulse polarity, so the postamble looks like a preamble
	assign p = rev ? neg : pos;
	assign n = rev ? pos : neg;
	assign in_bnd = (cnt_q >= CW'(HALF - QTR)) && (cnt_q <= CW'(HALF + QTR));
	assign late = cnt_q > CW'(HALF + QTR);
	assign lost = cnt_q == CW'(CELL_CLKS + QTR);

	always_ff @(posedge clk) begin
		if (rst || !en) begin
			cnt_q <= '0;
			lock_q <= 1'b0;
			vld_q <= 1'b0;
			bit_q <= 1'b0;
			pred_q <= 1'b0;
			bnd_q <= 1'b0;
			miss_q <= 1'b0;
		end else if (ce) begin
			if (take) begin
				vld_q <= 1'b0;
			end
			if (!lock_q) begin
				if (p || n) begin
					cnt_q <= '0;
				end else if (!lost) begin
					cnt_q <= cnt_q + 1'b1;
				end
				// a one after zeros has no boundary pulse: long gap, then positive
				// saturated count: no pulse before, e.g. trailing edge seen in reverse
				if (p && late && !lost) begin
					lock_q <= 1'b1;
					bit_q <= 1'b1;
					vld_q <= 1'b1;
					bnd_q <= 1'b0;
					miss_q <= 1'b0;
				end
			end else begin
				cnt_q <= cnt_q + 1'b1;
				if ((p || n) && in_bnd) begin
					pred_q <= n;
					bnd_q <= 1'b1;
				end else if ((p || n) && late) begin
					bit_q <= p;
					vld_q <= 1'b1;
					cnt_q <= '0;
					bnd_q <= 1'b0;
					miss_q <= 1'b0;
				end else if (lost) begin
					// mid pulse missing: infer from boundary, else opposite
					bit_q <= bnd_q ? pred_q : ~bit_q;
					vld_q <= 1'b1;
					cnt_q <= CW'(QTR);
					bnd_q <= 1'b0;
					miss_q <= 1'b1;
					if (miss_q) begin
						lock_q <= 1'b0;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/petc_tape_model.sv
`timescale 1ns/100ps
`default_nettype none
module petc_tape_model #(
	parameter int PAD = 200
) (
	input wire logic clk,
	input wire logic [8:0] wr_flux,
	input wire logic wr_en,
	input wire logic play,
	input wire logic rev,
	output logic [8:0] rd_pos,
	output logic [8:0] rd_neg,
	output logic done
);
	logic [8:0] tape[$];
	logic wr_en_p = 1'b0;
	logic play_p = 1'b0;
	int ph = -1;

	initial begin
		rd_pos = 9'h000;
		rd_neg = 9'h000;
		done = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// flux seen by track i at playback step j, erased outside the record
	function automatic logic fx(input int j, input int i);
		int n;
		int k;
		n = tape.size();
		k = j - PAD - (i % 3);
		if (k < 0 || k >= n) return 1'b1;
		return rev ? tape[n - 1 - k][i] : tape[k][i];
	endfunction

	always @(posedge clk) begin
		if (wr_en && !wr_en_p) tape.delete();
		if (wr_en) tape.push_back(wr_flux);
		wr_en_p <= wr_en;
	end

	////////////////////////////////////////////////////////////////
	// each flux change becomes a two-clock pulse, tracks skewed apart
	always @(posedge clk) begin
		play_p <= play;
		if (play && !play_p) begin
			ph <= 0;
			done <= 1'b0;
		end else if (ph >= 0) begin
			for (int i = 0; i < 9; i++) begin
				rd_pos[i] <= (fx(ph, i) && !fx(ph - 1, i)) || (fx(ph - 1, i) && !fx(ph - 2, i));
				rd_neg[i] <= (!fx(ph, i) && fx(ph - 1, i)) || (!fx(ph - 1, i) && fx(ph - 2, i));
			end
			if (ph >= tape.size() + 2 * PAD) begin
				ph <= -1;
				done <= 1'b1;
			end else begin
				ph <= ph + 1;
			end
		end else begin
			rd_pos <= 9'h000;
			rd_neg <= 9'h000;
		end
	end
endmodule
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int CELL = 40;
	localparam int IDC = 8;
	localparam int GAPC = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr_cmd_n = 1'b1;
	logic id_cmd_n = 1'b1;
	logic rd_cmd_n = 1'b1;
	logic rev_n = 1'b1;
	logic wr_req_n = 1'b1;
	logic wr_last_n = 1'b1;
	logic [7:0] wr_byte_n = 8'hFF;
	logic wr_ack_n, busy_n, rd_stb_n, rd_perr_n, wr_en, erase_on, done;
	logic play = 1'b0;
	logic [7:0] rd_data_n;
	logic [8:0] rd_pos, rd_neg, wr_flux;
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	logic [7:0] seed = 8'h23;
	logic [7:0] exp_q[$];
	logic [7:0] got_q[$];
	logic got_perr[$];
	int tt[$];
	logic id_mon = 1'b0;
	logic rd_mon = 1'b0;
	logic f3 = 1'b1;
	logic stb_p = 1'b1;

	always #20 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	petc_codec #(.CELL_CLKS(CELL), .ID_CELLS(IDC), .GAP_CELLS(GAPC), .STB_CLKS(2)) uut (
		.clk(clk), .rst(rst), .ce(1'b1), .wr_cmd_n(wr_cmd_n), .id_cmd_n(id_cmd_n),
		.rd_cmd_n(rd_cmd_n), .rev_n(rev_n), .wr_req_n(wr_req_n), .wr_last_n(wr_last_n),
		.wr_byte_n(wr_byte_n), .wr_ack_n(wr_ack_n), .busy_n(busy_n), .rd_data_n(rd_data_n),
		.rd_stb_n(rd_stb_n), .rd_perr_n(rd_perr_n), .rd_pos(rd_pos), .rd_neg(rd_neg),
		.wr_flux(wr_flux), .wr_en(wr_en), .erase_on(erase_on)
	);

	petc_tape_model #(.PAD(5 * CELL)) tape (
		.clk(clk), .wr_flux(wr_flux), .wr_en(wr_en), .play(play), .rev(~rev_n),
		.rd_pos(rd_pos), .rd_neg(rd_neg), .done(done)
	);

	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic final_report();
		if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk_val(input logic [8:0] got, input logic [8:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t %s: got %h expected %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_ok(input bit ok, input string m);
		checked++;
		if (!ok) begin
			num_errors++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask

	task automatic wait_for(ref logic s, input logic v, input int lim);
		for (int i = 0; i < lim && s !== v; i++) @(negedge clk);
		if (s !== v) begin
			num_errors++;
			$display("ERROR %0t wait limit ran out", $time);
			final_report();
		end
	endtask

	////////////////////////////////////////////////////////////////
	// burst on the parity track, then a clean gap before the preamble
	always @(negedge clk) if (id_mon) begin
		if ({wr_flux[8:4], wr_flux[2:0]} !== 8'hFF) begin
			id_mon = 1'b0;
			chk_ok(tt.size() >= IDC - 1, "burst too short");
			for (int k = 2; k < tt.size() - 1; k++)
				chk_ok(tt[k] - tt[k - 1] == CELL, "burst spacing");
			chk_ok(tt.size() > 0 && cyc - tt[tt.size() - 1] >= GAPC * CELL, "gap short");
		end else if (wr_flux[3] !== f3) begin
			f3 = wr_flux[3];
			tt.push_back(cyc);
		end
	end

	always @(negedge clk) begin
		if (rd_mon && rd_stb_n === 1'b0 && stb_p === 1'b1) begin
			got_q.push_back(~rd_data_n);
			got_perr.push_back(rd_perr_n);
		end
		stb_p = rd_stb_n;
	end

	////////////////////////////////////////////////////////////////
	// host side: strict four-phase byte handshake, inverted data
	task automatic send_block(input int n, input logic id);
		logic [7:0] b;
		exp_q.delete();
		tt.delete();
		f3 = 1'b1;
		id_mon = id;
		wr_cmd_n = 1'b0;
		id_cmd_n = ~id;
		for (int i = 0; i < n; i++) begin
			seed = lfsr(seed);
			b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed;
			exp_q.push_back(b);
			wr_byte_n = ~b;
			wr_last_n = (i == n - 1) ? 1'b0 : 1'b1;
			wr_req_n = 1'b0;
			wait_for(wr_ack_n, 1'b0, 100 * CELL);
			chk_val({8'h00, erase_on}, 9'h001, "erase off while writing");
			wr_req_n = 1'b1;
			wait_for(wr_ack_n, 1'b1, 10);
			@(negedge clk);
		end
		wr_cmd_n = 1'b1;
		id_cmd_n = 1'b1;
		wr_last_n = 1'b1;
		wait_for(busy_n, 1'b1, 200 * CELL);
		@(negedge clk);
	endtask

	task automatic read_block(input logic rv);
		int n;
		got_q.delete();
		got_perr.delete();
		rev_n = ~rv;
		rd_cmd_n = 1'b0;
		rd_mon = 1'b1;
		play = 1'b1;
		@(negedge clk);
		play = 1'b0;
		@(negedge clk);
		chk_val({8'h00, erase_on}, 9'h000, "erase on while reading");
		wait_for(done, 1'b1, 300 * CELL);
		repeat (6 * CELL) @(negedge clk);
		rd_mon = 1'b0;
		rd_cmd_n = 1'b1;
		rev_n = 1'b1;
		n = exp_q.size();
		chk_ok(got_q.size() == n, "byte count");
		for (int k = 0; k < n && k < got_q.size(); k++) begin
			chk_val({1'b0, got_q[k]}, {1'b0, rv ? exp_q[n - 1 - k] : exp_q[k]}, "read byte");
			chk_val({8'h00, got_perr[k]}, 9'h001, "parity flag");
		end
		@(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(negedge clk);
		chk_val(wr_flux, 9'h1FF, "flux at reset");
		chk_val({3'h0, wr_ack_n, busy_n, rd_stb_n, rd_perr_n, wr_en, erase_on}, 9'h03C, "reset outputs");
		chk_val({1'b0, rd_data_n}, 9'h0FF, "read data at reset");
		rst = 1'b0;
		repeat (3) @(negedge clk);
		send_block(4, 1'b1);
		send_block(7, 1'b0);
		read_block(1'b0);
		read_block(1'b1);
		final_report();
	end
endmodule
`default_nettype wire
